// ### common/lfs_pkg.sv
// shared constants and types for the led fault supervisor
package lfs_pkg;
  localparam int CLK_MHZ = 25;
  localparam int NSINK = 3;
  // times as printed
  localparam int OV_SOFT_US = 100;
  localparam int UV_US = 100;
  localparam int OV_ACT_MS = 560;
  localparam int OV_SHORT_MS = 50;
  localparam int OV_RESTORE_MS = 160;
  localparam int RECOVERY_MS = 100;
  localparam int FILT_US = 1;
  localparam int CLR_MIN_US = 2;
  localparam int CLR_MAX_US = 20;
  localparam int SOFT_START_US = 100;
  localparam int STEP_US = 10;
  // derived cycle counts
  localparam logic [23:0] OV_SOFT_CYC = 24'(OV_SOFT_US * CLK_MHZ);
  localparam logic [23:0] UV_CYC = 24'(UV_US * CLK_MHZ);
  localparam logic [23:0] OV_ACT_CYC = 24'(OV_ACT_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] OV_SHORT_CYC = 24'(OV_SHORT_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] RESTORE_CYC = 24'(OV_RESTORE_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] REC_CYC = 24'(RECOVERY_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] SOFT_CYC = 24'(SOFT_START_US * CLK_MHZ);
  localparam logic [4:0] FILT_CYC = 5'(FILT_US * CLK_MHZ);
  localparam logic [9:0] CLR_MIN_CYC = 10'(CLR_MIN_US * CLK_MHZ);
  localparam logic [9:0] CLR_MAX_CYC = 10'(CLR_MAX_US * CLK_MHZ);
  localparam logic [9:0] CLR_OVER_CYC = 10'(CLR_MAX_US * CLK_MHZ + 1);
  localparam logic [7:0] STEP_CYC = 8'(STEP_US * CLK_MHZ);
  localparam logic [23:0] TMR_MAX = 24'hFFFFFF;
  localparam logic [7:0] TARGET_MAX = 8'hFF;
  localparam logic [7:0] TARGET_MIN = 8'h00;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_STANDBY = 6'h02,
    ST_STARTUP = 6'h04,
    ST_SOFT = 6'h08,
    ST_ACTIVE = 6'h10,
    ST_RECOVERY = 6'h20
  } lfs_state_t;
endpackage

// ### hw/lfs_filter.sv
// persistence filter: hit once level has held for limit cycles
module lfs_filter
  import lfs_pkg::*;
  #(parameter int W = 24)
  (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // level to qualify
  input wire logic en_in,
  input wire logic level_in,
  input wire logic [W-1:0] limit_in,
  // qualified level
  output logic hit_out
  );

  logic [W-1:0] cnt;

  // any gap in the level restarts the count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= '0;
    end else if (!en_in || !level_in) begin
      cnt <= '0;
    end else if (cnt < limit_in) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign hit_out = en_in && level_in && (cnt >= limit_in);
endmodule

// ### hw/lfs_enable_pulse.sv
// measures enable-low width in active: blank, clear or standby request
module lfs_enable_pulse
  import lfs_pkg::*;
  (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic armed_in,
  input wire logic enable_in,
  // results
  output logic blank_out,
  output logic clear_out,
  output logic standby_out
  );

  logic [9:0] low_cnt;

  // saturates one past the window so a long low stays a long low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt <= 10'h000;
    end else if (!armed_in || enable_in) begin
      low_cnt <= 10'h000;
    end else if (low_cnt != CLR_OVER_CYC) begin
      low_cnt <= low_cnt + 10'h001;
    end
  end

  assign blank_out = armed_in && !enable_in;
  assign clear_out = armed_in && enable_in && (low_cnt >= CLR_MIN_CYC) && (low_cnt <= CLR_MAX_CYC);
  assign standby_out = armed_in && !enable_in && (low_cnt == CLR_OVER_CYC);
endmodule

// ### hw/lfs_supervisor.sv
// fault supervision and state control for a three-string led driver
module lfs_supervisor
  import lfs_pkg::*;
  #(
  parameter logic [23:0] OV_ACT_CYC_P = OV_ACT_CYC,
  parameter logic [23:0] OV_SHORT_CYC_P = OV_SHORT_CYC,
  parameter logic [23:0] RESTORE_CYC_P = RESTORE_CYC,
  parameter logic [23:0] REC_CYC_P = REC_CYC
  )
  (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // regulator and host
  input wire logic por_ok_in,
  input wire logic enable_input_in,
  // supply and thermal comparators
  input wire logic supply_ov_comp_in,
  input wire logic supply_uv_comp_in,
  input wire logic over_temp_comp_in,
  // per-sink comparators and ground sense
  input wire logic [2:0] sink_low_comp_in,
  input wire logic [2:0] sink_mid_comp_in,
  input wire logic [2:0] sink_high_comp_in,
  input wire logic [2:0] sink_grounded_in,
  // open-drain fault pin
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe_out,
  // power stage control
  output logic converter_en_out,
  output logic [2:0] sink_output_en_out,
  output logic [7:0] adaptive_target_voltage_out,
  // status
  output logic [5:0] state_out,
  output logic [2:0] sink_disabled_out,
  output logic supply_overvoltage_fault_out,
  output logic supply_undervoltage_fault_out,
  output logic over_temperature_fault_out,
  output logic open_string_fault_out,
  output logic shorted_string_fault_out
  );

  lfs_state_t st;
  lfs_state_t next_st;
  logic [23:0] tmr;
  logic [23:0] dwell;
  logic [23:0] ov_limit;
  logic ov_short;
  logic ov_hit;
  logic uv_hit;
  logic ot_hit;
  logic supply_fault;
  logic in_run;
  logic rec_exit;
  logic ov_flag;
  logic uv_flag;
  logic ot_flag;
  logic open_flag;
  logic short_flag;
  logic [2:0] sink_off;
  logic [2:0] mask;
  logic [2:0] low_f;
  logic [2:0] mid_f;
  logic [2:0] high_f;
  logic [2:0] win;
  logic [2:0] open_set;
  logic [2:0] short_set;
  logic [7:0] target;
  logic [7:0] step_cnt;
  logic step_tick;
  logic blank;
  logic clear_pulse;
  logic standby_req;
  logic [11:0] uv_run;

  assign in_run = (st == ST_SOFT) || (st == ST_ACTIVE);
  assign mask = ~sink_off;

  // overvoltage filter time follows the state and the shortened mode
  always_comb begin
    if (st == ST_SOFT) begin
      ov_limit = OV_SOFT_CYC;
    end else if (ov_short) begin
      ov_limit = OV_SHORT_CYC_P;
    end else begin
      ov_limit = OV_ACT_CYC_P;
    end
  end

  lfs_filter #(.W(24)) u_ov_filt (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .en_in(in_run),
    .level_in(supply_ov_comp_in),
    .limit_in(ov_limit),
    .hit_out(ov_hit)
  );

  // undervoltage is watched in every state past power-on
  lfs_filter #(.W(24)) u_uv_filt (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .en_in(st != ST_OFF),
    .level_in(supply_uv_comp_in),
    .limit_in(UV_CYC),
    .hit_out(uv_hit)
  );

  // comparator carries its own hysteresis, so its fall means cooled enough
  assign ot_hit = in_run && over_temp_comp_in;
  assign supply_fault = ov_hit || uv_hit || ot_hit;

  // per-sink 1 us filters and string fault detection
  generate
    for (genvar i = 0; i < NSINK; i++) begin : g_sink
      lfs_filter #(.W(5)) u_low (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(1'b1),
        .level_in(sink_low_comp_in[i]),
        .limit_in(FILT_CYC),
        .hit_out(low_f[i])
      );
      lfs_filter #(.W(5)) u_mid (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(1'b1),
        .level_in(sink_mid_comp_in[i]),
        .limit_in(FILT_CYC),
        .hit_out(mid_f[i])
      );
      lfs_filter #(.W(5)) u_high (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .en_in(1'b1),
        .level_in(sink_high_comp_in[i]),
        .limit_in(FILT_CYC),
        .hit_out(high_f[i])
      );
      assign win[i] = !low_f[i] && !mid_f[i];
      assign open_set[i] = (st == ST_ACTIVE) && (target == TARGET_MAX) && mask[i] && low_f[i];
      assign short_set[i] = (st == ST_ACTIVE) && mask[i] && high_f[i]
                            && |(win & mask & ~(3'(3'h1 << i)));
    end
  endgenerate

  lfs_enable_pulse u_pulse (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .armed_in(st == ST_ACTIVE),
    .enable_in(enable_input_in),
    .blank_out(blank),
    .clear_out(clear_pulse),
    .standby_out(standby_req)
  );

  assign rec_exit = (st == ST_RECOVERY) && (tmr >= REC_CYC_P) && !supply_ov_comp_in
                    && !supply_uv_comp_in && !over_temp_comp_in;

  always_comb begin
    next_st = st;
    case (st)
      ST_OFF: begin
        if (por_ok_in) begin
          next_st = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        // only enable matters here, but never start into a low supply
        if (enable_input_in && !uv_hit) begin
          next_st = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (uv_hit) begin
          next_st = ST_RECOVERY;
        end else if (!enable_input_in) begin
          next_st = ST_STANDBY;
        end else if (tmr == 24'(FILT_CYC)) begin
          next_st = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (supply_fault) begin
          next_st = ST_RECOVERY;
        end else if (!enable_input_in) begin
          next_st = ST_STANDBY;
        end else if (tmr == SOFT_CYC) begin
          next_st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // string faults do not leave active
        if (supply_fault) begin
          next_st = ST_RECOVERY;
        end else if (standby_req) begin
          next_st = ST_STANDBY;
        end
      end
      ST_RECOVERY: begin
        if (rec_exit) begin
          next_st = ST_ACTIVE;
        end
      end
      default: begin
        next_st = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= ST_OFF;
    end else begin
      st <= next_st;
    end
  end

  // shared state timer, restarts on every state change
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tmr <= 24'h000000;
    end else if (next_st != st) begin
      tmr <= 24'h000000;
    end else if (tmr != TMR_MAX) begin
      tmr <= tmr + 24'h000001;
    end
  end

  // time spent in active, for restoring the long filter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dwell <= 24'h000000;
    end else if (st != ST_ACTIVE) begin
      dwell <= 24'h000000;
    end else if (dwell != RESTORE_CYC_P) begin
      dwell <= dwell + 24'h000001;
    end
  end

  // set wins over the restore
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_short <= 1'b0;
    end else if (ov_hit) begin
      ov_short <= 1'b1;
    end else if (st == ST_ACTIVE && dwell == RESTORE_CYC_P) begin
      ov_short <= 1'b0;
    end
  end

  // adaptive target steps at a slow fixed pace so the loop can settle
  assign step_tick = (step_cnt == STEP_CYC);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_cnt <= 8'h00;
    end else if (st != ST_ACTIVE || step_tick) begin
      step_cnt <= 8'h00;
    end else begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      target <= TARGET_MIN;
    end else if (st == ST_STARTUP) begin
      target <= TARGET_MIN;
    end else if (st == ST_ACTIVE && step_tick) begin
      if (|(low_f & mask) && target != TARGET_MAX) begin
        target <= target + 8'h01;
      end else if (|mask && ((mid_f & mask) == mask) && target != TARGET_MIN) begin
        target <= target - 8'h01;
      end
    end
  end

  // disabled sinks leave both the loop and detection
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sink_off <= 3'h0;
    end else if (st == ST_STANDBY) begin
      sink_off <= 3'h0;
    end else if (st == ST_STARTUP && tmr == 24'(FILT_CYC)) begin
      sink_off <= sink_grounded_in;
    end else begin
      sink_off <= sink_off | open_set | short_set;
    end
  end

  // string fault flags: set wins over the clear pulse
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      open_flag <= 1'b0;
    end else if (|open_set) begin
      open_flag <= 1'b1;
    end else if (clear_pulse || st == ST_STANDBY) begin
      open_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      short_flag <= 1'b0;
    end else if (|short_set) begin
      short_flag <= 1'b1;
    end else if (clear_pulse || st == ST_STANDBY) begin
      short_flag <= 1'b0;
    end
  end

  // supply fault flags hold until recovery succeeds
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_flag <= 1'b0;
      ot_flag <= 1'b0;
    end else begin
      if (ov_hit) begin
        ov_flag <= 1'b1;
      end else if (rec_exit) begin
        ov_flag <= 1'b0;
      end
      if (ot_hit) begin
        ot_flag <= 1'b1;
      end else if (rec_exit) begin
        ot_flag <= 1'b0;
      end
    end
  end

  // in standby a low supply is flagged without a recovery cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uv_flag <= 1'b0;
    end else if (uv_hit) begin
      uv_flag <= 1'b1;
    end else if (rec_exit || (st == ST_STANDBY && !supply_uv_comp_in)) begin
      uv_flag <= 1'b0;
    end
  end

  // output drive
  assign converter_en_out = in_run;
  assign sink_output_en_out = (st == ST_ACTIVE && !blank) ? mask : 3'h0;
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe_out = (st == ST_RECOVERY) || open_flag || short_flag || uv_flag;
  assign adaptive_target_voltage_out = target;
  assign state_out = st;
  assign sink_disabled_out = sink_off;
  assign supply_overvoltage_fault_out = ov_flag;
  assign supply_undervoltage_fault_out = uv_flag;
  assign over_temperature_fault_out = ot_flag;
  assign open_string_fault_out = open_flag;
  assign shorted_string_fault_out = short_flag;

  // consecutive cycles of raw undervoltage, for checking the filter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uv_run <= 12'h000;
    end else if (!supply_uv_comp_in) begin
      uv_run <= 12'h000;
    end else if (uv_run != 12'hFFF) begin
      uv_run <= uv_run + 12'h001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_ov_soft;
    (st == ST_SOFT && ov_hit) |=> (st == ST_RECOVERY && supply_overvoltage_fault_out);
  endproperty
  a_ov_soft: assert property (p_ov_soft) else $error("soft start overvoltage not handled");

  property p_ov_limit;
    (st == ST_ACTIVE) |-> (ov_limit == (ov_short ? OV_SHORT_CYC_P : OV_ACT_CYC_P));
  endproperty
  a_ov_limit: assert property (p_ov_limit) else $error("wrong active overvoltage filter");

  property p_ov_short;
    ov_hit |=> ov_short;
  endproperty
  a_ov_short: assert property (p_ov_short) else $error("filter not shortened after fault");

  property p_restore;
    (st == ST_ACTIVE && dwell == RESTORE_CYC_P && !ov_hit) |=> !ov_short;
  endproperty
  a_restore: assert property (p_restore) else $error("long filter not restored");

  property p_uv;
    $rose(supply_undervoltage_fault_out) |-> ({12'h000, $past(uv_run)} >= UV_CYC);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage flagged too early");

  property p_ot;
    (st == ST_ACTIVE && over_temp_comp_in) |=> (st == ST_RECOVERY);
  endproperty
  a_ot: assert property (p_ot) else $error("over-temperature ignored");

  property p_rec_out;
    (st == ST_RECOVERY) |-> (!converter_en_out && sink_output_en_out == 3'h0 && fault_pin_oe_out);
  endproperty
  a_rec_out: assert property (p_rec_out) else $error("recovery outputs wrong");

  property p_rec_hold;
    (st == ST_RECOVERY && tmr < REC_CYC_P) |=> (st == ST_RECOVERY);
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("recovery left early");

  property p_open;
    (open_set != 3'h0) |=> (open_string_fault_out && fault_pin_oe_out
                            && ((sink_off & $past(open_set)) == $past(open_set)));
  endproperty
  a_open: assert property (p_open) else $error("open string not disabled");

  property p_short;
    (short_set != 3'h0 && !supply_fault) |=> (shorted_string_fault_out && st == ST_ACTIVE
                                             && ((sink_off & $past(short_set)) == $past(short_set)));
  endproperty
  a_short: assert property (p_short) else $error("shorted string not handled");

  property p_clear;
    (clear_pulse && open_set == 3'h0 && short_set == 3'h0 && !supply_fault)
      |=> (!open_string_fault_out && !shorted_string_fault_out && st == ST_ACTIVE);
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse did not release");

  property p_long_low;
    (standby_req && !supply_fault) |=> (st == ST_STANDBY);
  endproperty
  a_long_low: assert property (p_long_low) else $error("long enable low kept active");

  property p_start;
    (st == ST_STANDBY && enable_input_in && !uv_hit) |=> (st == ST_STARTUP);
  endproperty
  a_start: assert property (p_start) else $error("enable did not start device");
endmodule

// ### test/lfs_host_model.sv
// host model: drives enable and reads the open-drain fault pin
module lfs_host_model (
  // clock
  input wire logic clk_in,
  // pin side
  input wire logic fault_pin_in,
  output logic enable_out,
  output logic fault_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial enable_out = 1'h0;
  // pin is pulled up: low only while the device pulls it
  assign fault_seen_out = ~fault_pin_in;
  task automatic set_en(input logic v);
    @(negedge clk_in);
    enable_out = v;
  endtask
  // low for w whole cycles, then high again
  task automatic pulse(input int w);
    @(negedge clk_in);
    enable_out = 1'h0;
    repeat (w) @(negedge clk_in);
    enable_out = 1'h1;
  endtask
endmodule

// ### test/lfs_supervisor_tb.sv
// self-checking bench for the led fault supervisor
module lfs_supervisor_tb
  import lfs_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened counts handed to the design
  localparam int ACT = 400;
  localparam int SHRT = 100;
  localparam int RST = 300;
  localparam int REC = 200;
  typedef struct {logic [2:0] hi; int w; logic fl; logic [5:0] st; logic [2:0] dis;} lfs_row_t;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic por_ok = 1'h0;
  logic ov = 1'h0;
  logic uv = 1'h0;
  logic ot = 1'h0;
  logic [2:0] lo = 3'h0;
  logic [2:0] mid = 3'h0;
  logic [2:0] hi = 3'h0;
  logic [2:0] gnd = 3'h0;
  logic en, fpin, foe, fout, conv, fseen, fov, fuv, fot, fop, fsh;
  logic [2:0] sen, sdis;
  logic [7:0] tgt;
  logic [5:0] st;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  lfs_row_t rows[4] = '{
    '{3'h1, 40, 1'h1, ST_ACTIVE, 3'h1},
    '{3'h2, 60, 1'h0, ST_ACTIVE, 3'h2},
    '{3'h4, 490, 1'h0, ST_ACTIVE, 3'h4},
    '{3'h1, 520, 1'h0, ST_STARTUP, 3'h0}};
  // open drain with pull-up
  assign fpin = foe ? fout : 1'h1;

  lfs_supervisor #(.OV_ACT_CYC_P(24'(ACT)), .OV_SHORT_CYC_P(24'(SHRT)),
    .RESTORE_CYC_P(24'(RST)), .REC_CYC_P(24'(REC))) lfs_supervisor_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .por_ok_in(por_ok), .enable_input_in(en),
    .supply_ov_comp_in(ov), .supply_uv_comp_in(uv), .over_temp_comp_in(ot),
    .sink_low_comp_in(lo), .sink_mid_comp_in(mid), .sink_high_comp_in(hi),
    .sink_grounded_in(gnd), .fault_pin_in(fpin), .fault_pin_out(fout),
    .fault_pin_oe_out(foe), .converter_en_out(conv), .sink_output_en_out(sen),
    .adaptive_target_voltage_out(tgt), .state_out(st), .sink_disabled_out(sdis),
    .supply_overvoltage_fault_out(fov), .supply_undervoltage_fault_out(fuv),
    .over_temperature_fault_out(fot), .open_string_fault_out(fop),
    .shorted_string_fault_out(fsh));

  lfs_host_model lfs_host_model_inst (
    .clk_in(clk_in), .fault_pin_in(fpin), .enable_out(en), .fault_seen_out(fseen));

  initial forever #20 clk_in = ~clk_in;

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cy(input int k);
    repeat (k) @(negedge clk_in);
  endtask

  // bounded wait for a state; n returns cycles spent
  task automatic till(input logic [5:0] s, input int mx, output int n);
    n = 0;
    while (st !== s && n < mx) begin
      cy(1);
      n++;
    end
    chk("state", st, s);
  endtask

  task automatic restart(input logic [2:0] g, input logic [5:0] s);
    int n;
    lfs_host_model_inst.set_en(1'h0);
    rst_b_in = 1'h0;
    por_ok = 1'h0;
    gnd = g;
    cy(12);
    chk("rst_st", st, ST_OFF);
    chk("rst_oe", foe, 1'h0);
    chk("rst_tgt", tgt, 8'h00);
    rst_b_in = 1'h1;
    cy(3);
    chk("no_por", st, ST_OFF);
    por_ok = 1'h1;
    till(ST_STANDBY, 3, n);
    ov = 1'h1;
    ot = 1'h1;
    cy(10);
    chk("stby", st, ST_STANDBY);
    ov = 1'h0;
    ot = 1'h0;
    lfs_host_model_inst.set_en(1'h1);
    till(s, 3000, n);
  endtask

  // hang guard: longest path is the climb to the top target code
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    int n;
    int m;
    foreach (rows[i]) begin
      restart(3'h0, ST_ACTIVE);
      hi = rows[i].hi;
      cy(40);
      hi = 3'h0;
      chk("sh_flag", fsh, 1'h1);
      chk("sh_dis", sdis, rows[i].hi);
      chk("sh_sen", sen, 3'(~rows[i].hi));
      chk("sh_st", st, ST_ACTIVE);
      chk("sh_pin", fseen, 1'h1);
      fork
        lfs_host_model_inst.pulse(rows[i].w);
        begin
          cy(3);
          chk("blank", sen, 3'h0);
        end
      join
      cy(5);
      chk("clr_flag", fsh, rows[i].fl);
      chk("clr_pin", fseen, rows[i].fl);
      chk("clr_st", st, rows[i].st);
      chk("clr_dis", sdis, rows[i].dis);
    end
    // grounded sink and a short overvoltage burst in soft start
    restart(3'h4, ST_SOFT);
    gnd = 3'h0;
    ov = 1'h1;
    cy(2000);
    chk("soft_st", st, ST_SOFT);
    chk("soft_ov", fov, 1'h0);
    ov = 1'h0;
    till(ST_ACTIVE, 600, n);
    chk("gnd_dis", sdis, 3'h4);
    chk("gnd_sen", sen, 3'h3);
    ov = 1'h1;
    till(ST_RECOVERY, ACT + 50, n);
    chk("ov_long", n > ACT - 10 && n < ACT + 10, 1'h1);
    chk("rec_flag", fov, 1'h1);
    chk("rec_pin", fseen, 1'h1);
    chk("rec_conv", conv, 1'h0);
    chk("rec_sen", sen, 3'h0);
    cy(150);
    ov = 1'h0;
    till(ST_ACTIVE, 100, m);
    chk("rec_time", m + 150 > REC - 5 && m + 150 < REC + 10, 1'h1);
    chk("rec_pin2", fseen, 1'h0);
    ov = 1'h1;
    till(ST_RECOVERY, ACT, n);
    chk("ov_short", n > SHRT - 10 && n < SHRT + 10, 1'h1);
    ov = 1'h0;
    till(ST_ACTIVE, REC + 20, n);
    cy(RST + 20);
    ov = 1'h1;
    till(ST_RECOVERY, ACT + 50, n);
    chk("ov_back", n > ACT - 10, 1'h1);
    ov = 1'h0;
    till(ST_ACTIVE, REC + 20, n);
    uv = 1'h1;
    cy(2000);
    uv = 1'h0;
    // gap must reach the filter, or the count carries on
    cy(2);
    chk("uv_short", fuv, 1'h0);
    uv = 1'h1;
    till(ST_RECOVERY, 2600, n);
    chk("uv_time", n > UV_US * CLK_MHZ - 5 && n < UV_US * CLK_MHZ + 10, 1'h1);
    chk("uv_flag", fuv, 1'h1);
    uv = 1'h0;
    till(ST_ACTIVE, REC + 20, n);
    ot = 1'h1;
    till(ST_RECOVERY, 30, n);
    chk("ot_flag", fot, 1'h1);
    cy(REC + 50);
    chk("ot_hold", st, ST_RECOVERY);
    ot = 1'h0;
    till(ST_ACTIVE, 10, n);
    chk("ot_clr", fot, 1'h0);
    // open string needs the target at its top code
    lo = 3'h1;
    n = 0;
    while (fop !== 1'h1 && n < 66000) begin
      cy(1);
      n++;
    end
    chk("op_flag", fop, 1'h1);
    chk("op_tgt", tgt, TARGET_MAX);
    chk("op_dis", sdis, 3'h5);
    chk("op_sen", sen, 3'h2);
    chk("op_st", st, ST_ACTIVE);
    mid = 3'h2;
    cy(600);
    chk("op_loop", tgt < TARGET_MAX, 1'h1);
    // overvoltage held through the whole soft start
    mid = 3'h0;
    lo = 3'h0;
    restart(3'h0, ST_SOFT);
    ov = 1'h1;
    till(ST_RECOVERY, 2600, n);
    chk("ov_soft", n > OV_SOFT_US * CLK_MHZ - 5 && n < OV_SOFT_US * CLK_MHZ + 10, 1'h1);
    chk("ov_soft_flag", fov, 1'h1);
    ov = 1'h0;
    conclude();
  end
endmodule
